/* src/hdm_pkg.sv */
`default_nettype none

package hdm_pkg;

	// Register offsets on the software port (byte addresses, one word each)
	localparam logic [7:0] HDM_OFS_ROW_BOUNDARY0 = 8'h00;
	localparam logic [7:0] HDM_OFS_ROW_CONFIG = 8'h20;
	localparam logic [7:0] HDM_OFS_SEG_ATTR = 8'h24;
	localparam logic [7:0] HDM_OFS_SMM_SPACE_CONTROL = 8'h28;
	localparam logic [7:0] HDM_OFS_MEMORY_HOLE_CONTROL = 8'h2c;
	localparam logic [7:0] HDM_OFS_DRAM_CONTROL = 8'h30;
	localparam logic [7:0] HDM_OFS_REFRESH_RATE_CONTROL = 8'h34;
	localparam logic [7:0] HDM_OFS_CONFIG_ADDRESS_PORT = 8'h38;
	localparam logic [7:0] HDM_OFS_STATUS = 8'h3c;

	// Reset values
	localparam logic [7:0] HDM_RST_ROW_BOUNDARY = 8'h00;
	localparam logic [31:0] HDM_RST_ROW_CONFIG = 32'h0000_0000;
	localparam logic [25:0] HDM_RST_SEG_ATTR = 26'h000_0000;
	localparam logic [7:0] HDM_RST_DRAM_CONTROL = 8'h00;
	localparam logic [7:0] HDM_RST_REFRESH_RATE = 8'h00;

	// Field positions
	localparam int HDM_SMM_ENABLE_BIT = 0;
	localparam int HDM_HOLE_ENABLE_BIT = 0;
	localparam int HDM_DCTL_EDO_DETECT_BIT = 0;
	localparam int HDM_DCTL_BEDO_PROGRAM_BIT = 1;
	localparam int HDM_DCTL_TIMING_LSB = 4;
	localparam int HDM_RRC_FAST_REFRESH_BIT = 7;
	localparam int HDM_ROWCFG_WIDE_COL_BIT = 2;

	// Address landmarks
	localparam logic [31:0] HDM_DOS_LOW_TOP = 32'h0008_0000;
	localparam logic [31:0] HDM_VIDEO_BASE = 32'h000a_0000;
	localparam logic [31:0] HDM_EXPANSION_BASE = 32'h000c_0000;
	localparam logic [31:0] HDM_BIOS_BASE = 32'h000f_0000;
	localparam logic [31:0] HDM_EXTENDED_BASE = 32'h0010_0000;
	localparam logic [31:0] HDM_IOAPIC_BASE = 32'hfec0_0000;
	localparam logic [31:0] HDM_LAPIC_BASE = 32'hfee0_0000;
	localparam logic [31:0] HDM_HIGH_BIOS_BASE = 32'hffe0_0000;
	localparam logic [31:0] HDM_BEDO_PROGRAM_OFFSET = 32'h0002_1000;
	localparam logic [15:0] HDM_IO_CONFIG_ADDRESS = 16'h0cf8;
	localparam logic [15:0] HDM_IO_CONFIG_DATA = 16'h0cfc;
	localparam logic [7:0] HDM_MAX_BOUNDARY = 8'h80;
	localparam int HDM_ROWS = 8;
	localparam int HDM_SEGMENTS = 13;

	// Routing verdict of one host cycle
	typedef enum logic [2:0] {
		HDM_RT_PCI = 3'b001,
		HDM_RT_DRAM = 3'b010,
		HDM_RT_INTERNAL = 3'b100
	} hdm_route_e;

endpackage

`default_nettype wire

/* src/hdm_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - I/O interrupt controller window goes to PCI
// - Gap up to local interrupt base: PCI
// - Top 2 Mbytes always go to PCI
// - Video range to PCI without SMM RAM
// - SMM cycles reach DRAM when SMM enabled
// - PCI initiators never reach SMM space
// - Shadow segments route reads/writes by attributes
// - Never claim PCI masters in shadowed segments
// - Host I/O cycles go to PCI, except ports
// - Decode config address and data ports
// - Main memory 8 Mbytes to 1 Gbyte
// - Per-row type used with global timing
// - EDO detect mode set by control bit
// - Row base plus offset write issues program cycle
// - Page offset on low nine column lines
// - Twelve address lines from host bits 26:3
// - Row phase carries bits 24,23,21,20,19:12
// - Column phase carries bits 26,24,22,11:3
// - Wide rows put bit 25 on column 10
// - Legacy segments: four access states each
// - 1 Mbyte to top of memory is DRAM
module hdm_decode (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Software register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Host cycle request
	input wire logic host_valid,
	input wire logic [31:0] host_address_bus,
	input wire logic [31:0] host_wdata,
	input wire logic host_write,
	input wire logic host_io,
	input wire logic host_smm,
	// Host cycle verdict
	output logic route_valid,
	output logic route_pci,
	output logic route_dram,
	output logic route_internal,
	output logic [2:0] route_row,
	output logic [1:0] route_row_type,
	output logic [3:0] dram_timing,
	output logic [11:0] dram_multiplexed_addr_row,
	output logic [11:0] dram_multiplexed_addr_col,
	output logic config_data_access,
	// DRAM special cycles and modes
	output logic dram_edo_detect_mode,
	output logic bedo_program_cycle,
	output logic fast_refresh_cycle,
	// PCI initiator snoop
	input wire logic pci_valid,
	input wire logic [31:0] pci_addr,
	output logic pci_claim_valid,
	output logic pci_claim
);
	import hdm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Segment index 0..12 for the C0000-FFFFF area, 16-Kbyte steps below F0000
	function automatic logic [3:0] seg_index(input logic [31:0] a);
		logic [3:0] idx;
		idx = 4'hc;
		if (a < HDM_BIOS_BASE) begin
			idx = {1'b0, a[16:14]} + {a[17], 3'b000};
		end
		return idx;
	endfunction

	// True when an address lies in the shadowable legacy area
	function automatic logic in_shadow_area(input logic [31:0] a);
		return (a >= HDM_EXPANSION_BASE) && (a < HDM_EXTENDED_BASE);
	endfunction

	// First row whose cumulative boundary exceeds the address
	function automatic logic [3:0] row_pick(input logic [31:0] a, input logic [63:0] bnd);
		logic [3:0] r;
		r = 4'h8;
		for (int i = HDM_ROWS - 1; i >= 0; i--) begin
			if ({1'b0, bnd[i*8 +: 8]} > a[31:23]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// Top of main memory from the last boundary, capped at 1 Gbyte
	function automatic logic [31:0] top_of_memory(input logic [7:0] b);
		logic [7:0] c;
		c = (b > HDM_MAX_BOUNDARY) ? HDM_MAX_BOUNDARY : b;
		return {1'b0, c, 23'h000000};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Software registers

	logic [63:0] row_boundary_reg; // Eight 8-bit cumulative boundaries
	logic [31:0] row_config_reg; // Four bits per row: type[1:0], wide column[2]
	logic [25:0] seg_attr_reg; // Two bits per segment: read enable, write enable
	logic smm_space_control_reg; // SMM RAM enable
	logic memory_hole_control_reg; // 512-640 Kbyte hole to PCI
	logic [7:0] dram_control_reg; // EDO detect, BEDO program, timing
	logic [6:0] refresh_rate_control_reg; // Refresh rate code
	logic [31:0] config_address_port_reg; // Written by host I/O cycles
	logic [2:0] last_route_reg; // Verdict of the last host cycle

	// Write decode
	// Boundary slots take word-aligned offsets only, matching the read decode
	wire logic wr_boundary = reg_wr && (reg_addr[7:5] == HDM_OFS_ROW_BOUNDARY0[7:5]) && (reg_addr[1:0] == 2'h0);
	wire logic wr_row_config = reg_wr && (reg_addr == HDM_OFS_ROW_CONFIG);
	wire logic wr_seg_attr = reg_wr && (reg_addr == HDM_OFS_SEG_ATTR);
	wire logic wr_smm = reg_wr && (reg_addr == HDM_OFS_SMM_SPACE_CONTROL);
	wire logic wr_hole = reg_wr && (reg_addr == HDM_OFS_MEMORY_HOLE_CONTROL);
	wire logic wr_dram_control = reg_wr && (reg_addr == HDM_OFS_DRAM_CONTROL);
	wire logic wr_refresh = reg_wr && (reg_addr == HDM_OFS_REFRESH_RATE_CONTROL);
	wire logic [2:0] wr_row_index = reg_addr[4:2];

	// Fast refresh request rides on the refresh register write
	wire logic fast_refresh_req = wr_refresh && reg_wdata[HDM_RRC_FAST_REFRESH_BIT];

	// Boundary and layout registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			row_boundary_reg <= {HDM_ROWS{HDM_RST_ROW_BOUNDARY}};
			row_config_reg <= HDM_RST_ROW_CONFIG;
			seg_attr_reg <= HDM_RST_SEG_ATTR;
		end else begin
			if (wr_boundary) begin
				row_boundary_reg[wr_row_index*8 +: 8] <= reg_wdata[7:0];
			end
			if (wr_row_config) begin
				row_config_reg <= reg_wdata;
			end
			if (wr_seg_attr) begin
				seg_attr_reg <= reg_wdata[25:0];
			end
		end
	end

	// Mode and control registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			smm_space_control_reg <= 1'b0;
			memory_hole_control_reg <= 1'b0;
			refresh_rate_control_reg <= HDM_RST_REFRESH_RATE[6:0];
		end else begin
			if (wr_smm) begin
				smm_space_control_reg <= reg_wdata[HDM_SMM_ENABLE_BIT];
			end
			if (wr_hole) begin
				memory_hole_control_reg <= reg_wdata[HDM_HOLE_ENABLE_BIT];
			end
			if (wr_refresh) begin
				refresh_rate_control_reg <= reg_wdata[6:0];
			end
		end
	end

	// DRAM control; a fast refresh ends BEDO programming mode unless the same
	// write turns it on again, so software keeps the last word
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dram_control_reg <= HDM_RST_DRAM_CONTROL;
		end else if (wr_dram_control) begin
			dram_control_reg <= reg_wdata[7:0];
		end else if (fast_refresh_req) begin
			dram_control_reg[HDM_DCTL_BEDO_PROGRAM_BIT] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host cycle decode

	wire logic [31:0] ha = host_address_bus;
	wire logic [31:0] tom = top_of_memory(row_boundary_reg[63:56]);
	wire logic [3:0] host_seg = seg_index(ha);
	wire logic [1:0] host_attr = seg_attr_reg[host_seg*2 +: 2];

	// I/O space: only the two configuration ports belong to us
	wire logic io_cfg_addr = (ha[15:2] == HDM_IO_CONFIG_ADDRESS[15:2]) && (ha[31:16] == 16'h0000);
	wire logic io_cfg_data = (ha[15:2] == HDM_IO_CONFIG_DATA[15:2]) && (ha[31:16] == 16'h0000);

	// Memory windows: interrupt and high BIOS always PCI regardless of top of memory, video and DOS hole by mode
	wire logic in_ioapic = (ha >= HDM_IOAPIC_BASE) && (ha < HDM_LAPIC_BASE);
	wire logic in_high_bios = (ha >= HDM_HIGH_BIOS_BASE);
	wire logic in_video = (ha >= HDM_VIDEO_BASE) && (ha < HDM_EXPANSION_BASE);
	wire logic in_dos_hole = (ha >= HDM_DOS_LOW_TOP) && (ha < HDM_VIDEO_BASE);

	// Direction-dependent attribute: bit 0 read enable, bit 1 write enable
	wire logic attr_hit = host_write ? host_attr[1] : host_attr[0];

	// Memory verdict: DRAM or not
	logic mem_to_dram;
	always_comb begin
		mem_to_dram = 1'b0; // Anything unmatched falls to PCI
		if (in_ioapic || in_high_bios) begin
			mem_to_dram = 1'b0;
		end else if (ha < HDM_DOS_LOW_TOP) begin
			// Low DOS area has no attributes: plain DRAM below top of memory
			mem_to_dram = (ha < tom);
		end else if (in_dos_hole) begin
			mem_to_dram = !memory_hole_control_reg && (ha < tom);
		end else if (in_video) begin
			mem_to_dram = smm_space_control_reg && host_smm && (ha < tom);
		end else if (in_shadow_area(ha)) begin
			mem_to_dram = attr_hit && (ha < tom);
		end else begin
			mem_to_dram = (ha < tom);
		end
	end

	// Overall verdict
	hdm_route_e route_next;
	always_comb begin
		if (host_io) begin
			route_next = (io_cfg_addr || io_cfg_data) ? HDM_RT_INTERNAL : HDM_RT_PCI;
		end else if (mem_to_dram) begin
			route_next = HDM_RT_DRAM;
		end else begin
			route_next = HDM_RT_PCI;
		end
	end

	// Row selection and type
	wire logic [3:0] row_sel = row_pick(ha, row_boundary_reg);
	// Index 8 means no row; the fields below are only taken for DRAM-routed cycles
	wire logic [2:0] row_idx = row_sel[2:0];
	wire logic [3:0] row_cfg = row_config_reg[row_idx*4 +: 4];
	wire logic row_wide = row_cfg[HDM_ROWCFG_WIDE_COL_BIT];

	// Row base for the program-cycle match: previous boundary or zero
	wire logic [7:0] row_base_units = (row_idx == 3'd0) ? 8'h00 : row_boundary_reg[(row_idx - 3'd1)*8 +: 8];
	wire logic [31:0] row_base = {1'b0, row_base_units, 23'h000000};
	wire logic bedo_hit = dram_control_reg[HDM_DCTL_BEDO_PROGRAM_BIT] && host_write
		&& (ha == row_base + HDM_BEDO_PROGRAM_OFFSET);

	// Multiplexed address, row and column phases, from host bits 26:3
	wire logic [11:0] ma_row_next = {ha[24], ha[23], ha[21], ha[20], ha[19:12]};
	wire logic [11:0] ma_col_next = {ha[26], row_wide ? ha[25] : ha[24], ha[22], ha[11:3]};

	////////////////////////////////////////////////////////////////////////
	// Host verdict outputs, one cycle after the request

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			route_valid <= 1'b0;
			route_pci <= 1'b0;
			route_dram <= 1'b0;
			route_internal <= 1'b0;
			config_data_access <= 1'b0;
			bedo_program_cycle <= 1'b0;
		end else begin
			route_valid <= host_valid;
			route_pci <= host_valid && (route_next == HDM_RT_PCI);
			route_dram <= host_valid && (route_next == HDM_RT_DRAM);
			route_internal <= host_valid && (route_next == HDM_RT_INTERNAL);
			config_data_access <= host_valid && host_io && io_cfg_data;
			bedo_program_cycle <= host_valid && !host_io && (route_next == HDM_RT_DRAM) && bedo_hit;
		end
	end

	// Address and row fields; held from the last DRAM cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			route_row <= 3'h0;
			route_row_type <= 2'h0;
			dram_multiplexed_addr_row <= 12'h000;
			dram_multiplexed_addr_col <= 12'h000;
		end else if (host_valid && !host_io && mem_to_dram) begin
			route_row <= row_idx;
			route_row_type <= row_cfg[1:0];
			dram_multiplexed_addr_row <= ma_row_next;
			dram_multiplexed_addr_col <= ma_col_next;
		end
	end

	// Configuration address port and last verdict
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			config_address_port_reg <= 32'h0000_0000;
			last_route_reg <= 3'h0;
		end else begin
			if (host_valid && host_io && host_write && io_cfg_addr) begin
				config_address_port_reg <= host_wdata;
			end
			if (host_valid) begin
				last_route_reg <= route_next;
			end
		end
	end

	// Mode outputs, mirrored from control registers; fast refresh pulses from the refresh register write
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dram_edo_detect_mode <= 1'b0;
			dram_timing <= 4'h0;
			fast_refresh_cycle <= 1'b0;
		end else begin
			dram_edo_detect_mode <= dram_control_reg[HDM_DCTL_EDO_DETECT_BIT];
			dram_timing <= dram_control_reg[HDM_DCTL_TIMING_LSB +: 4];
			fast_refresh_cycle <= fast_refresh_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PCI initiator snoop: claim only plain DRAM below top of memory

	wire logic pci_in_smm = (pci_addr >= HDM_VIDEO_BASE) && (pci_addr < HDM_EXPANSION_BASE);
	wire logic pci_in_hole = memory_hole_control_reg && (pci_addr >= HDM_DOS_LOW_TOP) && (pci_addr < HDM_VIDEO_BASE);
	// Shadowed blocks are never claimed, even when enabled for the host
	wire logic pci_claim_next = (pci_addr < tom) && !pci_in_smm && !in_shadow_area(pci_addr) && !pci_in_hole;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pci_claim_valid <= 1'b0;
			pci_claim <= 1'b0;
		end else begin
			pci_claim_valid <= pci_valid;
			pci_claim <= pci_valid && pci_claim_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read port, data one cycle after the strobe

	wire logic [2:0] rd_row_index = reg_addr[4:2];
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			HDM_OFS_ROW_CONFIG: rd_mux = row_config_reg;
			HDM_OFS_SEG_ATTR: rd_mux = {6'h00, seg_attr_reg};
			HDM_OFS_SMM_SPACE_CONTROL: rd_mux = {31'h0000_0000, smm_space_control_reg};
			HDM_OFS_MEMORY_HOLE_CONTROL: rd_mux = {31'h0000_0000, memory_hole_control_reg};
			HDM_OFS_DRAM_CONTROL: rd_mux = {24'h00_0000, dram_control_reg};
			HDM_OFS_REFRESH_RATE_CONTROL: rd_mux = {25'h000_0000, refresh_rate_control_reg}; // Fast bit reads 0
			HDM_OFS_CONFIG_ADDRESS_PORT: rd_mux = config_address_port_reg;
			HDM_OFS_STATUS: rd_mux = {29'h0000_0000, last_route_reg};
			default: begin
				// Boundaries, else unmapped reads as zero
				if (reg_addr[7:5] == HDM_OFS_ROW_BOUNDARY0[7:5] && reg_addr[1:0] == 2'h0) begin
					rd_mux = {24'h00_0000, row_boundary_reg[rd_row_index*8 +: 8]};
				end else begin
					rd_mux = 32'h0000_0000;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

endmodule // hdm_decode

`default_nettype wire

/* sim/hdm_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host processor and PCI initiator that issue cycles into the decoder
module hdm_far_model (
	// Clock
	input wire logic sys_clk,
	// Host cycle
	output var logic host_valid,
	output var logic [31:0] host_address_bus,
	output var logic [31:0] host_wdata,
	output var logic host_write,
	output var logic host_io,
	output var logic host_smm,
	// PCI initiator
	output var logic pci_valid,
	output var logic [31:0] pci_addr
);
	// Idle bus at time zero
	initial begin
		host_valid = 1'b0;
		host_address_bus = 32'h0;
		host_wdata = 32'h0;
		host_write = 1'b0;
		host_io = 1'b0;
		host_smm = 1'b0;
		pci_valid = 1'b0;
		pci_addr = 32'h0;
	end

	// One host cycle; address inverted afterwards so stale values never match
	task automatic host_cyc(input logic [31:0] a, input logic w, io, s, input logic [31:0] d);
		@(posedge sys_clk);
		host_valid <= 1'b1;
		host_address_bus <= a;
		host_wdata <= d;
		host_write <= w;
		host_io <= io;
		host_smm <= s;
		@(posedge sys_clk);
		host_valid <= 1'b0;
		host_address_bus <= ~a;
		host_wdata <= ~d;
	endtask

	// One PCI initiator address phase offered for claiming
	task automatic pci_cyc(input logic [31:0] a);
		@(posedge sys_clk);
		pci_valid <= 1'b1;
		pci_addr <= a;
		@(posedge sys_clk);
		pci_valid <= 1'b0;
		pci_addr <= ~a;
	endtask
endmodule // hdm_far_model

`default_nettype wire

/* sim/hdm_decode_props.sv */
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the routing verdict and address multiplexing
module hdm_decode_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Host side
	input wire logic host_valid,
	input wire logic [31:0] host_address_bus,
	input wire logic host_io,
	input wire logic host_smm,
	// Verdict
	input wire logic route_valid,
	input wire logic route_pci,
	input wire logic route_dram,
	input wire logic route_internal,
	input wire logic [11:0] dram_multiplexed_addr_row,
	input wire logic [11:0] dram_multiplexed_addr_col,
	input wire logic config_data_access,
	// PCI snoop
	input wire logic pci_valid,
	input wire logic [31:0] pci_addr,
	input wire logic pci_claim_valid,
	input wire logic pci_claim
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////
	// Helper decode of the request
	wire logic [31:0] ha = host_address_bus;
	wire logic mem = host_valid && !host_io;
	wire logic iov = host_valid && host_io;
	wire logic cfg = ha[31:16] == 16'h0000 && (ha[15:2] == 14'h033e || ha[15:2] == 14'h033f);
	wire logic p_legacy = pci_addr >= 32'h000a_0000 && pci_addr < 32'h0010_0000;
	// Address of the previous cycle, so the mux checks see the request
	logic [31:0] pa;
	always_ff @(posedge sys_clk) begin
		pa <= host_address_bus;
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_verdict_follows: assert property (
		host_valid |=> route_valid && $onehot({route_pci, route_dram, route_internal}))
		else $error("verdict missing or not one-hot");
	a_no_stray_verdict: assert property (!host_valid |=> !route_valid)
		else $error("verdict without request");
	a_apic_gap_pci: assert property (mem && ha >= 32'hfec0_0000 && ha < 32'hfee0_0000 |=> route_pci)
		else $error("interrupt window not sent to PCI");
	a_high_bios_pci: assert property (mem && ha >= 32'hffe0_0000 |=> route_pci)
		else $error("top 2 MB not sent to PCI");
	a_video_pci: assert property (mem && !host_smm && ha >= 32'h000a_0000 && ha < 32'h000c_0000 |=> route_pci)
		else $error("video range not sent to PCI");
	a_io_forward: assert property (iov && !cfg |=> route_pci)
		else $error("I/O cycle not forwarded");
	a_cfg_data_hit: assert property (iov && cfg && ha[2] |=> route_internal && config_data_access)
		else $error("data port not decoded");
	a_cfg_addr_hit: assert property (iov && cfg && !ha[2] |=> route_internal && !config_data_access)
		else $error("address port not decoded");
	a_ma_row_map: assert property (route_dram |-> dram_multiplexed_addr_row == {pa[24], pa[23], pa[21:12]})
		else $error("row address wrong");
	a_ma_col_map: assert property (
		route_dram |-> {dram_multiplexed_addr_col[11], dram_multiplexed_addr_col[9:0]} == {pa[26], pa[22], pa[11:3]})
		else $error("column address wrong");
	a_pci_legacy_excl: assert property (pci_valid && p_legacy |=> pci_claim_valid && !pci_claim)
		else $error("PCI claim in SMM or shadow range");

	// Main scenarios reached
	c_dram: cover property (route_dram);
	c_cfg: cover property (route_internal && config_data_access);
	c_claim: cover property (pci_claim);
endmodule // hdm_decode_props

bind hdm_decode hdm_decode_props u_props (.*);

`default_nettype wire

/* sim/hdm_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// Register and host-cycle driven tests of the decoder
module hdm_decode_tb;
	import hdm_pkg::*;
	// Bench-driven inputs
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	// Far side and design outputs
	wire logic host_valid, host_write, host_io, host_smm, pci_valid;
	wire logic [31:0] host_address_bus, host_wdata, pci_addr, reg_rdata;
	wire logic route_valid, route_pci, route_dram, route_internal, config_data_access;
	wire logic dram_edo_detect_mode, bedo_program_cycle, fast_refresh_cycle, pci_claim_valid, pci_claim;
	wire logic [2:0] route_row;
	wire logic [1:0] route_row_type;
	wire logic [3:0] dram_timing;
	wire logic [11:0] dram_multiplexed_addr_row, dram_multiplexed_addr_col;
	int n_fail = 0;
	int num_checks = 0;
	logic [31:0] a = 32'h06ab_cde8;
	// Addresses that must reach PCI whatever the map
	logic [31:0] hc_list [6] = '{32'hfec0_0000, 32'hfec0_fff8, 32'hfed0_0000,
		32'hfedf_fff8, 32'hffe0_0000, 32'hffff_fff0};

	always #2.5 sys_clk = ~sys_clk;
	hdm_decode u_dut (.*);
	hdm_far_model u_far (.*);

	////////////////////////////////////////////////////////////////////////////
	// Compare, bus and closing tasks
	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string m);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e, m);
	endtask
	task automatic hc(input logic [31:0] ad, input logic w, io, s, input hdm_route_e e, input string m);
		u_far.host_cyc(ad, w, io, s, ad ^ 32'h5a5a_0000);
		#1 chk({route_internal, route_dram, route_pci}, e, m);
	endtask
	task automatic pc(input logic [31:0] ad, input logic e, input string m);
		u_far.pci_cyc(ad);
		#1 chk({pci_claim_valid, pci_claim}, {1'b1, e}, m);
	endtask
	task automatic stop_test();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Watchdog; the whole run needs under a microsecond
	initial begin
		#20000;
		n_fail++;
		$display("[FAIL] %0t watchdog", $time);
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(HDM_OFS_ROW_BOUNDARY0 + 8'h1c, 32'h0, "boundary reset");
		rd(HDM_OFS_SEG_ATTR, 32'h0, "segment reset");
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, 32'h0, "unmapped");
		hc(32'h0010_0000, 0, 0, 0, HDM_RT_PCI, "no memory");
		$display("end reset");
		// Rows: 8 MB then 120 MB, top of memory 128 MB
		wr(HDM_OFS_ROW_BOUNDARY0, 32'h1);
		for (int i = 1; i < 8; i++) begin
			wr(HDM_OFS_ROW_BOUNDARY0 + 8'(4 * i), 32'h10);
		end
		hc(32'h0010_0000, 0, 0, 0, HDM_RT_DRAM, "extended");
		chk(route_row, 32'h0, "row0");
		hc(32'h0080_0000, 0, 0, 0, HDM_RT_DRAM, "row1 base");
		chk(route_row, 32'h1, "row1");
		hc(32'h0800_0000, 0, 0, 0, HDM_RT_PCI, "at top");
		// Boundary beyond the largest array is clamped at 1 GB
		wr(HDM_OFS_ROW_BOUNDARY0 + 8'h1c, 32'hff);
		hc(32'h3fff_fff8, 0, 0, 0, HDM_RT_DRAM, "1G-8");
		hc(32'h4000_0000, 0, 0, 0, HDM_RT_PCI, "1G");
		foreach (hc_list[i]) hc(hc_list[i], i[0], 0, 0, HDM_RT_PCI, "apic/bios");
		wr(HDM_OFS_ROW_BOUNDARY0 + 8'h1c, 32'h10);
		$display("end map");
		// SMM space
		hc(32'h000a_0000, 0, 0, 1, HDM_RT_PCI, "smm off");
		wr(HDM_OFS_SMM_SPACE_CONTROL, 32'h1);
		hc(32'h000b_fff8, 1, 0, 1, HDM_RT_DRAM, "smm on");
		hc(32'h000a_0000, 0, 0, 0, HDM_RT_PCI, "not smm");
		rd(HDM_OFS_CONFIG_ADDRESS_PORT, 32'h0, "save port");
		pc(32'h000a_0000, 0, "pci smm");
		$display("end smm");
		// Shadowing: segment 0 write-only, segment 12 read-only, segment 1 off
		wr(HDM_OFS_SEG_ATTR, 32'h0100_0002);
		hc(32'h000c_0000, 0, 0, 0, HDM_RT_PCI, "wo read");
		hc(32'h000c_0000, 1, 0, 0, HDM_RT_DRAM, "wo write");
		hc(32'h000f_0000, 0, 0, 0, HDM_RT_DRAM, "ro read");
		hc(32'h000f_fff8, 1, 0, 0, HDM_RT_PCI, "ro write");
		hc(32'h000c_4000, 1, 0, 0, HDM_RT_PCI, "disabled");
		pc(32'h000c_0000, 0, "pci shadow");
		pc(32'h000f_0000, 0, "pci bios");
		pc(32'h0010_0000, 1, "pci dram");
		hc(32'h0008_0000, 0, 0, 0, HDM_RT_DRAM, "no hole");
		wr(HDM_OFS_MEMORY_HOLE_CONTROL, 32'h1);
		hc(32'h0009_fff8, 0, 0, 0, HDM_RT_PCI, "hole");
		$display("end shadow");
		// I/O space
		hc(32'h0000_0080, 1, 1, 0, HDM_RT_PCI, "io");
		hc(32'h0000_0cf8, 1, 1, 0, HDM_RT_INTERNAL, "cfg addr");
		rd(HDM_OFS_CONFIG_ADDRESS_PORT, 32'h5a5a_0cf8, "cfg port");
		hc(32'h0000_0cfc, 0, 1, 0, HDM_RT_INTERNAL, "cfg data");
		chk(config_data_access, 32'h1, "data hit");
		hc(32'h0001_0cf8, 0, 1, 0, HDM_RT_PCI, "alias");
		rd(HDM_OFS_STATUS, 32'h1, "status pci");
		$display("end io");
		// Address mux, narrow then wide row 1
		wr(HDM_OFS_ROW_CONFIG, 32'h10);
		hc(a, 0, 0, 0, HDM_RT_DRAM, "mux");
		chk(dram_multiplexed_addr_row, {a[24], a[23], a[21:12]}, "row");
		chk(dram_multiplexed_addr_col, {a[26], a[24], a[22], a[11:3]}, "col");
		chk(route_row_type, 32'h1, "type");
		wr(HDM_OFS_ROW_CONFIG, 32'h60);
		hc(a, 1, 0, 0, HDM_RT_DRAM, "mux wide");
		chk(dram_multiplexed_addr_col, {a[26], a[25], a[22], a[11:3]}, "col wide");
		chk(route_row_type, 32'h2, "type wide");
		$display("end mux");
		// Detection modes and burst-order programming
		wr(HDM_OFS_DRAM_CONTROL, 32'hb1);
		@(posedge sys_clk);
		#1 chk(dram_edo_detect_mode, 32'h1, "edo mode");
		chk(dram_timing, 32'hb, "timing");
		wr(HDM_OFS_DRAM_CONTROL, 32'hb2);
		u_far.host_cyc(32'h0082_1000, 1, 0, 0, 32'h0);
		#1 chk(bedo_program_cycle, 32'h1, "program cycle");
		wr(HDM_OFS_REFRESH_RATE_CONTROL, 32'h80);
		#1 chk(fast_refresh_cycle, 32'h1, "fast refresh");
		rd(HDM_OFS_DRAM_CONTROL, 32'hb0, "program exit");
		$display("end dram");
		stop_test();
	end
endmodule // hdm_decode_tb

`default_nettype wire
